// ===== common/timer16_pkg.sv
/*
 * Shared constants and carriers for the 16-bit interval / pulse / capture
 * timer: register byte offsets, field positions, mode and clock codes,
 * divider sizes and the Avalon-MM request and answer structs.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package timer16_pkg;

   // Register byte offsets, one aligned word each
   localparam logic [5:0] OFS_MODE     = 6'h00;
   localparam logic [5:0] OFS_CAPCOMP  = 6'h04;
   localparam logic [5:0] OFS_PCMP     = 6'h08;
   localparam logic [5:0] OFS_SCMP     = 6'h0c;
   localparam logic [5:0] OFS_PRESCALE = 6'h10;
   localparam logic [5:0] OFS_OUTCTRL  = 6'h14;
   localparam logic [5:0] OFS_COUNT    = 6'h18;
   localparam logic [5:0] OFS_CAPTURE  = 6'h1c;
   localparam logic [5:0] OFS_STATUS   = 6'h20;

   // Field positions
   localparam int PRS_CLK_LO  = 0;  // Count clock select, 2 bits
   localparam int PRS_EDGE_LO = 4;  // Primary edge select, 2 bits
   localparam int OUT_EN      = 0;  // Timer output enable
   localparam int OUT_PINV    = 1;  // Invert on primary match
   localparam int OUT_INIT    = 2;  // Level held while stopped
   localparam int OUT_SINV    = 4;  // Invert on secondary match
   localparam int ST_PMATCH   = 0;
   localparam int ST_SMATCH   = 1;
   localparam int ST_CAP      = 2;
   localparam int ST_OVF      = 3;

   // Reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // Divider sizes of the two prescaled count clocks
   localparam int DIV_A_LOG2 = 4;
   localparam int DIV_B_LOG2 = 6;

   // Edge select codes; 2'b10 is prohibited
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef enum logic [1:0] {MODE_STOP, MODE_INTERVAL, MODE_FREE, MODE_RESTART} mode_t;
   typedef enum logic [1:0] {CLK_FULL, CLK_DIV_A, CLK_DIV_B, CLK_EDGE} clk_sel_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avmm_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } avmm_rsp_t;

endpackage

// ===== hdl/timer16_tick_filter.sv
/*
 * Count clock prescaler and capture pin filter. Produces a one-cycle tick
 * per count clock and a one-cycle valid-edge pulse aligned with it.
 * Assumes the pin is already synchronous to clk.
 */
`timescale 1ns/1ps
module timer16_tick_filter #(
   parameter int DIV_A_LOG2 = timer16_pkg::DIV_A_LOG2,
   parameter int DIV_B_LOG2 = timer16_pkg::DIV_B_LOG2
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Control
   input  wire logic       run,
   input  wire logic [1:0] clk_sel,
   input  wire logic [1:0] edge_sel,
   // Capture pin
   input  wire logic       pin,
   // Tick and filtered edge
   output logic            tick,
   output logic            edge_hit
);

   if (DIV_A_LOG2 < 1 || DIV_A_LOG2 >= DIV_B_LOG2) begin : g_bad_div
      $error("Divider sizes must satisfy 1 <= A < B");
   end

   logic [DIV_B_LOG2-1:0] div_reg, div_next;
   logic [1:0]            smp_reg, smp_next;
   logic                  level_reg, level_next;
   logic                  tick_next, hit_next;
   logic                  strobe, change, edge_ok;

   // Prescaler, two-sample filter and edge qualification
   always_comb begin
      div_next = run ? div_reg + 1'b1 : '0;
      unique case (timer16_pkg::clk_sel_t'(clk_sel))
         timer16_pkg::CLK_FULL:  strobe = 1'b1;
         timer16_pkg::CLK_DIV_A: strobe = &div_reg[DIV_A_LOG2-1:0];
         timer16_pkg::CLK_DIV_B: strobe = &div_reg;
         timer16_pkg::CLK_EDGE:  strobe = 1'b1;  // Event count samples every clk
      endcase
      smp_next = strobe ? {smp_reg[0], pin} : smp_reg;
      change   = strobe && (smp_next[1] == smp_next[0]) && (smp_next[0] != level_reg);
      unique case (edge_sel)
         timer16_pkg::EDGE_FALL: edge_ok = !smp_next[0];
         timer16_pkg::EDGE_RISE: edge_ok = smp_next[0];
         timer16_pkg::EDGE_BOTH: edge_ok = 1'b1;
         default:                edge_ok = 1'b0;  // Prohibited code never fires
      endcase
      level_next = change ? smp_next[0] : level_reg;
      // While stopped, track the pin so a restart sees no stale edge
      if (!run) begin
         smp_next   = {pin, pin};
         level_next = pin;
      end
      hit_next  = run && change && edge_ok;
      tick_next = run && ((clk_sel == timer16_pkg::CLK_EDGE) ? hit_next : strobe);
   end

   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_reg   <= '0;
         smp_reg   <= 2'h0;
         level_reg <= 1'b0;
         tick      <= 1'b0;
         edge_hit  <= 1'b0;
      end else begin
         div_reg   <= div_next;
         smp_reg   <= smp_next;
         level_reg <= level_next;
         tick      <= tick_next;
         edge_hit  <= hit_next;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_div_a_tick;
      tick && run && clk_sel == timer16_pkg::CLK_DIV_A && $stable(clk_sel);
   endsequence

   a_edge_prohibited: assert property (edge_sel == 2'h2 |=> !edge_hit)
      else $error("Edge fired with prohibited select");
   a_div_a_spacing: assert property (s_div_a_tick ##1 $stable(clk_sel) && run
                                     |-> (!tick)[*8])
      else $error("Divided tick came too soon");
   a_filter_twice: assert property (edge_hit |-> $past(smp_reg[0]) == $past(pin))
      else $error("Edge without two equal samples");

endmodule // timer16_tick_filter

// ===== hdl/timer16_interval_ppg_capture.sv
/*
 * 16-bit timer: interval timer, pulse output and pulse-width capture,
 * with an Avalon-MM register slave (one wait state per access).
 * Assumes pins synchronous to clk and a master that holds its request
 * until waitrequest is sampled low.
 */
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module timer16_interval_ppg_capture #(
   parameter int INSTANCE   = 0,
   parameter int DIV_A_LOG2 = timer16_pkg::DIV_A_LOG2,
   parameter int DIV_B_LOG2 = timer16_pkg::DIV_B_LOG2
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Avalon-MM slave
   input  wire timer16_pkg::avmm_req_t bus_req,
   output timer16_pkg::avmm_rsp_t      bus_rsp,
   // Timer pins
   input  wire logic                   capture_in_primary,
   output logic                        timer_out_pin,
   // Interrupt request pulses
   output logic                        primary_match_irq,
   output logic                        secondary_match_irq,
   output logic                        capture_irq
);

   if (INSTANCE < 0 || INSTANCE > 1) begin : g_bad_inst
      $error("INSTANCE must be 0 or 1");
   end

   localparam bit CAN_CAPTURE = (INSTANCE == 0);

   timer16_pkg::mode_t mode_reg, mode_next;
   logic [2:0]  capcomp_ctrl, capcomp_next;
   logic [15:0] primary_compare_reg, pcmp_next;
   logic [15:0] secondary_compare_reg, scmp_next;
   logic [7:0]  prescaler_mode_reg, prs_next;
   logic [7:0]  output_ctrl_reg, outc_next;
   logic [15:0] up_counter, count_next;
   logic [15:0] capture_reg_secondary, cap_next;
   logic [3:0]  status_reg, status_next, status_set, status_clr;
   logic        level_reg, level_next;
   logic        pin_next;
   logic [2:0]  irq_next;
   logic        waitreq_reg, waitreq_next;
   logic [31:0] rdata_reg, rdata_next, wval;
   logic        wr_acc, tick, hit, pmatch, smatch, cap_ok;

   // Read view of one register; unmapped offsets read zero
   function automatic logic [31:0] reg_view(input logic [5:0] addr);
      unique case (addr)
         timer16_pkg::OFS_MODE:     reg_view = {30'h0, mode_reg};
         timer16_pkg::OFS_CAPCOMP:  reg_view = {29'h0, capcomp_ctrl};
         timer16_pkg::OFS_PCMP:     reg_view = {16'h0, primary_compare_reg};
         timer16_pkg::OFS_SCMP:     reg_view = {16'h0, secondary_compare_reg};
         timer16_pkg::OFS_PRESCALE: reg_view = {24'h0, prescaler_mode_reg};
         timer16_pkg::OFS_OUTCTRL:  reg_view = {24'h0, output_ctrl_reg};
         timer16_pkg::OFS_COUNT:    reg_view = {16'h0, up_counter};
         timer16_pkg::OFS_CAPTURE:  reg_view = {16'h0, capture_reg_secondary};
         timer16_pkg::OFS_STATUS:   reg_view = {28'h0, status_reg};
         default:                   reg_view = timer16_pkg::RST_WORD;
      endcase
   endfunction

   // Byte-lane merge of write data over the current value
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  be);
      for (int i = 0; i < 4; i++) begin
         lane_merge[8*i +: 8] = be[i] ? data[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   timer16_tick_filter #(
      .DIV_A_LOG2 (DIV_A_LOG2),
      .DIV_B_LOG2 (DIV_B_LOG2)
   ) u_tick (
      .clk      (clk),
      .reset    (reset),
      .run      (mode_reg != timer16_pkg::MODE_STOP),
      .clk_sel  (prescaler_mode_reg[timer16_pkg::PRS_CLK_LO +: 2]),
      .edge_sel (prescaler_mode_reg[timer16_pkg::PRS_EDGE_LO +: 2]),
      .pin      (capture_in_primary),
      .tick     (tick),
      .edge_hit (hit)
   );

   // Bus handshake: every access gets exactly one wait state
   always_comb begin
      wr_acc       = bus_req.write && !waitreq_reg;
      waitreq_next = !((bus_req.read || bus_req.write) && waitreq_reg);
      rdata_next   = reg_view(bus_req.address);
      wval         = lane_merge(reg_view(bus_req.address), bus_req.writedata,
                                bus_req.byteenable);
   end

   // Configuration registers written by software
   always_comb begin
      mode_next    = mode_reg;
      capcomp_next = capcomp_ctrl;
      pcmp_next    = primary_compare_reg;
      scmp_next    = secondary_compare_reg;
      prs_next     = prescaler_mode_reg;
      outc_next    = output_ctrl_reg;
      if (wr_acc) begin
         unique case (bus_req.address)
            timer16_pkg::OFS_MODE:     mode_next    = timer16_pkg::mode_t'(wval[1:0]);
            timer16_pkg::OFS_CAPCOMP:  capcomp_next = wval[2:0];
            timer16_pkg::OFS_PCMP:     pcmp_next    = wval[15:0];
            timer16_pkg::OFS_SCMP:     scmp_next    = wval[15:0];
            timer16_pkg::OFS_PRESCALE: prs_next     = wval[7:0];
            timer16_pkg::OFS_OUTCTRL:  outc_next    = wval[7:0];
            default:                   mode_next    = mode_reg;  // Read-only or unmapped
         endcase
      end
   end

   // Counter, capture, output level and event flags
   always_comb begin
      pmatch     = (up_counter == primary_compare_reg);
      smatch     = (up_counter == secondary_compare_reg);
      cap_ok     = CAN_CAPTURE && hit && (mode_reg == timer16_pkg::MODE_FREE ||
                                          mode_reg == timer16_pkg::MODE_RESTART);
      count_next = up_counter;
      cap_next   = capture_reg_secondary;
      level_next = level_reg;
      status_set = 4'h0;
      irq_next   = 3'h0;
      if (mode_reg == timer16_pkg::MODE_STOP) begin
         count_next = timer16_pkg::RST_COUNT;
         level_next = output_ctrl_reg[timer16_pkg::OUT_INIT];
      end else if (tick) begin
         count_next = up_counter + 16'h0001;
         if (mode_reg == timer16_pkg::MODE_INTERVAL && pmatch) begin
            count_next = timer16_pkg::RST_COUNT;
         end
         if (pmatch) begin
            irq_next[0]                      = 1'b1;
            status_set[timer16_pkg::ST_PMATCH] = 1'b1;
         end
         if (pmatch && output_ctrl_reg[timer16_pkg::OUT_PINV]) begin
            level_next = !level_reg;
         end
         if (smatch) begin
            irq_next[1]                      = 1'b1;
            status_set[timer16_pkg::ST_SMATCH] = 1'b1;
            if (output_ctrl_reg[timer16_pkg::OUT_SINV]) begin
               level_next = !level_next;
            end
         end
         if (mode_reg != timer16_pkg::MODE_INTERVAL && up_counter == 16'hffff) begin
            status_set[timer16_pkg::ST_OVF] = 1'b1;
         end
         if (cap_ok) begin
            cap_next                       = up_counter;
            irq_next[2]                    = 1'b1;
            status_set[timer16_pkg::ST_CAP] = 1'b1;
            if (mode_reg == timer16_pkg::MODE_RESTART) begin
               count_next = timer16_pkg::RST_COUNT;
            end
         end
      end
      // Write one to clear; a set in the same cycle wins
      status_clr  = (wr_acc && bus_req.address == timer16_pkg::OFS_STATUS &&
                     bus_req.byteenable[0]) ? bus_req.writedata[3:0] : 4'h0;
      status_next = (status_reg & ~status_clr) | status_set;
      pin_next    = output_ctrl_reg[timer16_pkg::OUT_EN] && level_next;
   end

   // Bus answer registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         waitreq_reg <= 1'b1;
         rdata_reg   <= timer16_pkg::RST_WORD;
      end else begin
         waitreq_reg <= waitreq_next;
         rdata_reg   <= rdata_next;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_reg              <= timer16_pkg::MODE_STOP;
         capcomp_ctrl          <= 3'h0;
         primary_compare_reg   <= timer16_pkg::RST_COUNT;
         secondary_compare_reg <= timer16_pkg::RST_COUNT;
         prescaler_mode_reg    <= 8'h00;
         output_ctrl_reg       <= 8'h00;
      end else begin
         mode_reg              <= mode_next;
         capcomp_ctrl          <= capcomp_next;
         primary_compare_reg   <= pcmp_next;
         secondary_compare_reg <= scmp_next;
         prescaler_mode_reg    <= prs_next;
         output_ctrl_reg       <= outc_next;
      end
   end

   // Counting state and pin outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         up_counter            <= timer16_pkg::RST_COUNT;
         capture_reg_secondary <= timer16_pkg::RST_COUNT;
         status_reg            <= 4'h0;
         level_reg             <= 1'b0;
         timer_out_pin         <= 1'b0;
         primary_match_irq     <= 1'b0;
         secondary_match_irq   <= 1'b0;
         capture_irq           <= 1'b0;
      end else begin
         up_counter            <= count_next;
         capture_reg_secondary <= cap_next;
         status_reg            <= status_next;
         level_reg             <= level_next;
         timer_out_pin         <= pin_next;
         primary_match_irq     <= irq_next[0];
         secondary_match_irq   <= irq_next[1];
         capture_irq           <= irq_next[2];
      end
   end

   assign bus_rsp.waitrequest = waitreq_reg;
   assign bus_rsp.readdata    = rdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_req_waiting;
      (bus_req.read || bus_req.write) && waitreq_reg;
   endsequence
   sequence s_interval_match;
      tick && mode_reg == timer16_pkg::MODE_INTERVAL && pmatch;
   endsequence
   sequence s_free_capture;
      CAN_CAPTURE && tick && hit && mode_reg == timer16_pkg::MODE_FREE;
   endsequence

   a_bus_answer: assert property (s_req_waiting |=> !waitreq_reg)
      else $error("No answer one cycle after request");
   a_bus_release: assert property (!waitreq_reg |=> waitreq_reg)
      else $error("Waitrequest low for more than one cycle");
   a_interval_clear: assert property (s_interval_match
                                      |=> up_counter == 16'h0000 && primary_match_irq)
      else $error("Primary match did not clear and interrupt");
   a_interval_step: assert property (tick && !pmatch
                                     && mode_reg == timer16_pkg::MODE_INTERVAL
                                     |=> up_counter == $past(up_counter) + 16'h0001)
      else $error("Counter did not step by one");
   a_overflow_set: assert property (tick && up_counter == 16'hffff
                                    && mode_reg == timer16_pkg::MODE_FREE
                                    |=> status_reg[timer16_pkg::ST_OVF]
                                    && up_counter == 16'h0000)
      else $error("Wrap did not set overflow");
   a_capture_copy: assert property (s_free_capture
                                    |=> capture_reg_secondary == $past(up_counter) && capture_irq)
      else $error("Capture did not copy counter");
   a_restart_clear: assert property (tick && cap_ok
                                     && mode_reg == timer16_pkg::MODE_RESTART
                                     |=> up_counter == 16'h0000)
      else $error("Restart capture did not clear counter");
   a_ppg_width: assert property (tick && smatch && !pmatch
                                 && mode_reg != timer16_pkg::MODE_STOP
                                 && output_ctrl_reg[timer16_pkg::OUT_SINV]
                                 && output_ctrl_reg[timer16_pkg::OUT_EN]
                                 |=> timer_out_pin != $past(timer_out_pin))
      else $error("Output did not toggle on secondary match");

endmodule // timer16_interval_ppg_capture

// ===== testbench/timer16_pulse_source.sv
/*
 * Pulse source standing on the capture pin of the timer.
 * Assumes go is a one-cycle request from the bench, synchronous to clk.
 */
`timescale 1ns/1ps
module timer16_pulse_source (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Request from the bench
   input  wire logic        go,
   input  wire logic [15:0] len,
   // Capture pin
   output logic             pin
);
   logic [15:0] left_reg;

   // pin driven as input
   // Holds the pin high for len clocks, low otherwise; a len of 1 is a glitch
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         left_reg <= 16'h0000;
      end else if (go) begin
         left_reg <= len;
      end else if (left_reg != 16'h0000) begin
         left_reg <= left_reg - 16'h0001;
      end
   end

   assign pin = (left_reg != 16'h0000);
endmodule // timer16_pulse_source

// ===== testbench/timer16_interval_ppg_capture_test.sv
/*
 * Self-checking bench for the 16-bit timer: registers, interval,
 * pulse output, capture filter and overflow flag.
 * Assumes the timer answers on its Avalon-MM port by waitrequest.
 */
`timescale 1ns/1ps
module timer16_interval_ppg_capture_test;
   logic                   clk;
   logic                   reset;
   timer16_pkg::avmm_req_t bus_req;
   timer16_pkg::avmm_rsp_t bus_rsp;
   logic                   cap_pin;
   logic                   timer_out_pin;
   logic                   primary_match_irq;
   logic                   secondary_match_irq;
   logic                   capture_irq;
   logic                   go;
   logic [15:0]            plen;
   logic [31:0]            rd;
   logic [31:0]            c1;
   int                     n_mismatch;
   int                     samples_checked;
   int                     cycles;
   int                     n_cap;
   int                     a, b, p, s, len;
   logic [1:0]             codes [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h3};

   timer16_interval_ppg_capture dut (
      .clk                (clk),
      .reset              (reset),
      .bus_req            (bus_req),
      .bus_rsp            (bus_rsp),
      .capture_in_primary (cap_pin),
      .timer_out_pin      (timer_out_pin),
      .primary_match_irq  (primary_match_irq),
      .secondary_match_irq(secondary_match_irq),
      .capture_irq        (capture_irq)
   );

   timer16_pulse_source src (
      .clk  (clk),
      .reset(reset),
      .go   (go),
      .len  (plen),
      .pin  (cap_pin)
   );

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Capture pulse counter and hang guard
   always @(posedge clk) begin
      cycles++;
      if (capture_irq === 1'b1) n_cap++;
      if (cycles == 90000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_mismatch++;
      end
   endtask

   // One bus access; request held until waitrequest is sampled low,
   // only the run-wide timeout limits the wait
   task xfer(input logic w, input logic [5:0] ad, input logic [31:0] d);
      bus_req.read <= ~w;
      bus_req.write <= w;
      bus_req.address <= ad;
      bus_req.writedata <= d;
      bus_req.byteenable <= 4'hf;
      do begin
         @(posedge clk);
      end while (bus_rsp.waitrequest !== 1'b0);
      rd = bus_rsp.readdata;
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [5:0] ad, input int d);
      xfer(1'b1, ad, 32'(d));
   endtask

   task rdr(input logic [5:0] ad);
      xfer(1'b0, ad, 32'h0000_0000);
   endtask

   task pulse(input int n);
      go <= 1'b1;
      plen <= 16'(n);
      @(posedge clk);
      go <= 1'b0;
   endtask

   function logic sig(input int sel);
      case (sel)
         0: return primary_match_irq;
         1: return timer_out_pin;
         default: return capture_irq;
      endcase
   endfunction

   // Cycles until the chosen output reaches lvl, bounded
   task wait_sig(input int sel, input logic lvl, output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (sig(sel) !== lvl && c < 70000);
   endtask

   function int period(input int cmp, input int sel);
      if (sel == 1) return (cmp + 1) << timer16_pkg::DIV_A_LOG2;
      if (sel == 2) return (cmp + 1) << timer16_pkg::DIV_B_LOG2;
      return cmp + 1;
   endfunction

   // Code 10 and short glitches give nothing; both edges give two
   function int caps(input logic [1:0] code, input int n);
      if (n < 2 || code == 2'h2) return 0;
      return (code == 2'h3) ? 2 : 1;
   endfunction

   initial begin
      bus_req = '0;
      go = 1'b0;
      plen = 16'h0000;
      reset = 1'b1;
      void'($urandom(1136));
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      // Reset words, an unmapped place and the read-only counter
      for (a = 0; a < 10; a++) begin
         rdr(6'(a * 4));
         check("reset word", 32'h0000_0000, rd);
      end
      wr(6'h24, -1);
      rdr(6'h24);
      check("unmapped", 32'h0000_0000, rd);
      wr(timer16_pkg::OFS_COUNT, 32'h1234);
      rdr(timer16_pkg::OFS_COUNT);
      check("count", 32'h0000_0000, rd);
      $display("test registers done");
      // Interval at each internal count clock, smallest compare first
      for (b = 0; b < 3; b++) begin
         p = (b == 0) ? 1 : 1 + $urandom_range(30);
         wr(timer16_pkg::OFS_CAPCOMP, 0);
         wr(timer16_pkg::OFS_PCMP, p);
         wr(timer16_pkg::OFS_PRESCALE, b);
         wr(timer16_pkg::OFS_MODE, 1);
         wait_sig(0, 1'b1, len);
         wait_sig(0, 1'b1, len);
         check("interval period", 32'(period(p, b)), 32'(len));
         wr(timer16_pkg::OFS_MODE, 0);
      end
      $display("test interval done");
      // Pulse output with duty at both bounds and in between
      for (b = 0; b < 3; b++) begin
         p = 2 + $urandom_range(20);
         s = (b == 0) ? 0 : (b == 1) ? p - 1 : $urandom_range(p - 1);
         wr(timer16_pkg::OFS_CAPCOMP, 0);
         wr(timer16_pkg::OFS_PCMP, p);
         wr(timer16_pkg::OFS_SCMP, s);
         wr(timer16_pkg::OFS_OUTCTRL, 32'h17);
         wr(timer16_pkg::OFS_PRESCALE, 0);
         wr(timer16_pkg::OFS_MODE, 1);
         wait_sig(1, 1'b0, len);
         wait_sig(1, 1'b1, a);
         wait_sig(1, 1'b0, len);
         check("pulse high", 32'(s + 1), 32'(len));
         check("pulse period", 32'(p + 1), 32'(a + len));
         wr(timer16_pkg::OFS_MODE, 0);
      end
      $display("test pulse output done");
      // Duty change on the run: inversion off, new width, one count clock, back on
      wr(timer16_pkg::OFS_PCMP, 60);
      wr(timer16_pkg::OFS_SCMP, 50);
      wr(timer16_pkg::OFS_MODE, 1);
      wait_sig(1, 1'b0, a);
      wait_sig(1, 1'b1, a);
      s = 20 + $urandom_range(20);
      wr(timer16_pkg::OFS_OUTCTRL, 32'h07);
      wr(timer16_pkg::OFS_SCMP, s);
      @(posedge clk);
      wr(timer16_pkg::OFS_OUTCTRL, 32'h17);
      wr(timer16_pkg::OFS_STATUS, 32'h2);
      wait_sig(1, 1'b0, a);
      wait_sig(1, 1'b1, a);
      wait_sig(1, 1'b0, len);
      check("new pulse high", 32'(s + 1), 32'(len));
      wr(timer16_pkg::OFS_MODE, 0);
      $display("test duty change done");
      // Every edge code, then a one-clock glitch
      for (b = 0; b < 5; b++) begin
         len = (b == 4) ? 1 : 12 + $urandom_range(20);
         wr(timer16_pkg::OFS_PRESCALE, 32'(codes[b]) << 4);
         wr(timer16_pkg::OFS_MODE, 2);
         a = n_cap;
         pulse(len);
         repeat (len + 10) @(posedge clk);
         check("capture count", 32'(caps(codes[b], len)), 32'(n_cap - a));
         wr(timer16_pkg::OFS_MODE, 0);
      end
      $display("test edge codes done");
      // Width from two captures on both edges
      wr(timer16_pkg::OFS_PRESCALE, 32'h30);
      wr(timer16_pkg::OFS_MODE, 2);
      len = 10 + $urandom_range(40);
      pulse(len);
      wait_sig(2, 1'b1, a);
      rdr(timer16_pkg::OFS_CAPTURE);
      c1 = rd;
      wait_sig(2, 1'b1, a);
      rdr(timer16_pkg::OFS_CAPTURE);
      check("pulse width", 32'(len), rd - c1);
      rdr(timer16_pkg::OFS_STATUS);
      check("capture flag", 32'h4, rd & 32'h4);
      $display("test capture done");
      // Capture then restart: the cleared counter reads len-1 at the far edge
      wr(timer16_pkg::OFS_MODE, 0);
      wr(timer16_pkg::OFS_MODE, 3);
      len = 10 + $urandom_range(40);
      pulse(len);
      wait_sig(2, 1'b1, a);
      wait_sig(2, 1'b1, a);
      rdr(timer16_pkg::OFS_CAPTURE);
      check("restart width", 32'(len - 1), rd);
      // Filtered rising pin edges as the count clock
      wr(timer16_pkg::OFS_MODE, 0);
      wr(timer16_pkg::OFS_PRESCALE, 32'h13);
      wr(timer16_pkg::OFS_MODE, 2);
      for (b = 0; b < 3; b++) begin
         pulse(4);
         repeat (8) @(posedge clk);
      end
      rdr(timer16_pkg::OFS_COUNT);
      check("event count", 32'h3, rd);
      $display("test restart and event count done");
      // Wrap of the free-running counter, then software clear
      wr(timer16_pkg::OFS_MODE, 0);
      wr(timer16_pkg::OFS_PRESCALE, 0);
      wr(timer16_pkg::OFS_STATUS, 32'hf);
      wr(timer16_pkg::OFS_MODE, 2);
      repeat (65540) @(posedge clk);
      rdr(timer16_pkg::OFS_STATUS);
      check("overflow set", 32'h8, rd & 32'h8);
      wr(timer16_pkg::OFS_STATUS, 32'h8);
      rdr(timer16_pkg::OFS_STATUS);
      check("overflow clear", 32'h0, rd & 32'h8);
      $display("test overflow done");
      give_verdict();
   end
endmodule // timer16_interval_ppg_capture_test
